// ---- design/pmbus_port_pkg.sv ----
// Shared constants and types of the serial command port
package pmbus_port_pkg;

	// ==============================
	// Framing
	localparam int         ADDR_W        = 7;
	localparam int         BYTE_W        = 8;
	localparam int         WORD_W        = 16;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT   = 4'h7;
	localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
	localparam logic       DIR_READ      = 1'b1;
	localparam logic       LINE_NACK     = 1'b1;
	localparam logic       SDA_LOW       = 1'b0;

	// ==============================
	// Byte counts of one operation
	localparam logic [1:0] WR_CNT_ZERO   = 2'h0;
	localparam logic [1:0] WR_CNT_CMD    = 2'h1;
	localparam logic [1:0] WR_CNT_MAX    = 2'h3;
	localparam logic [7:0] PTR_RESET     = 8'h00;

	// ==============================
	// Buffered write entry: pointer, byte index, data
	localparam int         ENTRY_W       = BYTE_W + 1 + BYTE_W;
	localparam int         BUF_DEPTH     = 2;

	// ==============================
	// Bus timeout
	localparam int         TIMEOUT_MS    = 35;
	localparam int         MCLK_HZ       = 20_000_000;
	localparam int         TIMEOUT_CYC   = TIMEOUT_MS * (MCLK_HZ / 1000);

	// ==============================
	// Port states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WR   = 3'b010,
		ST_ACK  = 3'b011,
		ST_RD   = 3'b100,
		ST_MACK = 3'b101,
		ST_RDHI = 3'b110,
		ST_WAIT = 3'b111
	} port_state_t;

	// ==============================
	// Open-drain enable for one data bit
	function automatic logic drive_for(input logic bit_val);
		drive_for = (bit_val == SDA_LOW);
	endfunction

endpackage

// ---- design/stream_if.sv ----
// Valid/ready stream carrier between the port modules
`timescale 1ns/10ps
interface stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (
		output valid,
		output data,
		input  ready
	);
	modport snk (
		input  valid,
		input  data,
		output ready
	);
endinterface

// ---- design/wr_buffer.sv ----
// Two-entry buffer for received write bytes
`timescale 1ns/10ps
module wr_buffer
	import pmbus_port_pkg::*;
#(
	parameter int W     = ENTRY_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input  wire logic mclk,
	input  wire logic reset,
	stream_if.snk     fill,
	stream_if.src     drain
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic          do_push;
	logic          do_pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign fill.ready  = (cnt_r != CW'(DEPTH));
	assign drain.valid = (cnt_r != '0);
	assign drain.data  = mem[rp_r];
	assign do_push     = fill.valid & fill.ready;
	assign do_pop      = drain.valid & drain.ready;

	// ==============================
	// Storage
	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem[wp_r] <= fill.data;
		end
	end

	// ==============================
	// Pointers and fill level
	always_ff @(posedge mclk) begin
		if (reset) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push) begin
				wp_r <= ptr_inc(wp_r);
			end
			if (do_pop) begin
				rp_r <= ptr_inc(rp_r);
			end
			if (do_push && !do_pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

endmodule

// ---- design/pmbus_slave_command_port.sv ----
// Slave command port of the two-wire management bus
`timescale 1ns/10ps
module pmbus_slave_command_port
	import pmbus_port_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic [ADDR_W-1:0] dev_addr,
	input  wire logic              timeout_en,
	input  wire logic              word_cmd,
	input  wire logic [WORD_W-1:0] rd_data,
	output logic [BYTE_W-1:0]      cmd_ptr,
	output logic                   cmd_strobe,
	output logic                   rd_strobe,
	output logic                   clear_faults,
	output logic                   wr_valid,
	input  wire logic              wr_ready,
	output logic [BYTE_W-1:0]      wr_ptr,
	output logic                   wr_index,
	output logic [BYTE_W-1:0]      wr_data
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	// ==============================
	// Declarations
	logic              scl_m_r;
	logic              scl_s_r;
	logic              scl_d_r;
	logic              sda_m_r;
	logic              sda_s_r;
	logic              sda_d_r;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              byte_end;
	logic              tmo_hit;
	logic [TW-1:0]     idle_cnt_r;
	port_state_t       state_r;
	logic [3:0]        bit_cnt_r;
	logic [BYTE_W-1:0] rx_r;
	logic [BYTE_W-1:0] tx_r;
	logic              drive_r;
	logic              rnw_r;
	logic              cmd_seen_r;
	logic              send_only_r;
	logic [1:0]        wr_cnt_r;
	logic              addr_match;
	logic              addr_ack;
	logic              cmd_take;
	logic              data_take;
	logic              push_fire;
	logic              clear_r;
	logic              cmd_stb_r;
	logic              rd_stb_r;

	stream_if #(.W(ENTRY_W)) push_if ();
	stream_if #(.W(ENTRY_W)) drain_if ();

	// ==============================
	// Pin synchronisers
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign scl_rise  = scl_s_r & ~scl_d_r;
	assign scl_fall  = ~scl_s_r & scl_d_r;
	assign start_det = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
	assign stop_det  = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
	assign byte_end  = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

	// ==============================
	// Byte decisions
	assign addr_match = (rx_r[BYTE_W-1:1] == dev_addr);
	// Reads need a command written earlier in this operation
	assign addr_ack   = addr_match && ((rx_r[0] != DIR_READ) || cmd_seen_r);
	assign cmd_take   = (state_r == ST_WR) && byte_end && (wr_cnt_r == WR_CNT_ZERO);
	assign data_take  = (state_r == ST_WR) && byte_end && (wr_cnt_r != WR_CNT_ZERO)
	                    && (wr_cnt_r != WR_CNT_MAX);
	// Full buffer refuses the byte with a not-acknowledge, nothing is lost silently
	assign push_fire  = data_take && push_if.ready;

	// ==============================
	// Timeout
	always_ff @(posedge mclk) begin
		if (reset) begin
			idle_cnt_r <= '0;
		end else if (state_r == ST_IDLE || scl_rise || scl_fall
		             || (sda_s_r != sda_d_r)) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != TW'(TIMEOUT_CYCLES)) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	assign tmo_hit = timeout_en && (idle_cnt_r == TW'(TIMEOUT_CYCLES));

	// ==============================
	// Bus state machine
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= BIT_CNT_ZERO;
			rx_r      <= '0;
			tx_r      <= '0;
			drive_r   <= 1'b0;
			rnw_r     <= 1'b0;
			wr_cnt_r  <= WR_CNT_ZERO;
		end else if (start_det) begin
			state_r   <= ST_ADDR;
			bit_cnt_r <= BIT_CNT_ZERO;
			drive_r   <= 1'b0;
			wr_cnt_r  <= WR_CNT_ZERO;
		end else if (stop_det || tmo_hit) begin
			state_r <= ST_IDLE;
			drive_r <= 1'b0;
		end else begin
			case (state_r)
			ST_ADDR, ST_WR: begin
				if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
					rx_r      <= {rx_r[BYTE_W-2:0], sda_s_r};
					bit_cnt_r <= bit_cnt_r + 1'b1;
				end else if (byte_end && state_r == ST_ADDR) begin
					rnw_r <= rx_r[0];
					if (addr_ack) begin
						drive_r <= 1'b1;
						state_r <= ST_ACK;
					end else begin
						state_r <= ST_WAIT;
					end
				end else if (byte_end) begin
					if (cmd_take || push_fire) begin
						drive_r  <= 1'b1;
						wr_cnt_r <= wr_cnt_r + 1'b1;
						state_r  <= ST_ACK;
					end else begin
						state_r <= ST_WAIT;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					bit_cnt_r <= BIT_CNT_ZERO;
					if (rnw_r) begin
						tx_r    <= rd_data[BYTE_W-1:0];
						drive_r <= drive_for(rd_data[BYTE_W-1]);
						state_r <= ST_RD;
					end else begin
						drive_r <= 1'b0;
						state_r <= ST_WR;
					end
				end
			end
			ST_RD: begin
				if (scl_fall) begin
					if (bit_cnt_r == LAST_TX_BIT) begin
						drive_r <= 1'b0;
						state_r <= ST_MACK;
					end else begin
						tx_r      <= {tx_r[BYTE_W-2:0], 1'b0};
						drive_r   <= drive_for(tx_r[BYTE_W-2]);
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					// Master acknowledge after the low byte of a word asks for the high byte
					if (sda_s_r == LINE_NACK || !word_cmd || wr_cnt_r == WR_CNT_MAX) begin
						state_r <= ST_WAIT;
					end else begin
						wr_cnt_r <= WR_CNT_MAX;
						state_r  <= ST_RDHI;
					end
				end
			end
			ST_RDHI: begin
				if (scl_fall) begin
					bit_cnt_r <= BIT_CNT_ZERO;
					tx_r      <= rd_data[WORD_W-1:BYTE_W];
					drive_r   <= drive_for(rd_data[WORD_W-1]);
					state_r   <= ST_RD;
				end
			end
			default: begin
				drive_r <= 1'b0;
			end
			endcase
		end
	end

	// ==============================
	// Operation tracking and send byte
	always_ff @(posedge mclk) begin
		if (reset) begin
			cmd_seen_r  <= 1'b0;
			send_only_r <= 1'b0;
			clear_r     <= 1'b0;
		end else begin
			clear_r <= stop_det && send_only_r;
			if (stop_det || tmo_hit) begin
				cmd_seen_r  <= 1'b0;
				send_only_r <= 1'b0;
			end else if (cmd_take) begin
				cmd_seen_r  <= 1'b1;
				send_only_r <= 1'b1;
			end else if (data_take || (start_det && cmd_seen_r)) begin
				// Any data byte, even a refused one, or a repeated start ends send byte
				send_only_r <= 1'b0;
			end
		end
	end

	// ==============================
	// Command pointer and strobes
	always_ff @(posedge mclk) begin
		if (reset) begin
			cmd_ptr   <= PTR_RESET;
			cmd_stb_r <= 1'b0;
			rd_stb_r  <= 1'b0;
		end else begin
			cmd_stb_r <= cmd_take;
			rd_stb_r  <= (state_r == ST_ADDR) && byte_end && addr_ack
			             && (rx_r[0] == DIR_READ);
			if (cmd_take) begin
				cmd_ptr <= rx_r;
			end
		end
	end

	// ==============================
	// Write byte path into the buffer
	assign push_if.valid = data_take;
	assign push_if.data  = {cmd_ptr, (wr_cnt_r != WR_CNT_CMD), rx_r};

	wr_buffer #(
		.W     (ENTRY_W),
		.DEPTH (BUF_DEPTH)
	) u_wr_buffer (
		.mclk  (mclk),
		.reset (reset),
		.fill  (push_if.snk),
		.drain (drain_if.src)
	);

	assign drain_if.ready = wr_ready;

	// ==============================
	// Outputs
	assign sda_out      = SDA_LOW;
	assign sda_oe       = drive_r;
	assign cmd_strobe   = cmd_stb_r;
	assign rd_strobe    = rd_stb_r;
	assign clear_faults = clear_r;
	assign wr_valid     = drain_if.valid;
	assign wr_ptr       = drain_if.data[ENTRY_W-1:BYTE_W+1];
	assign wr_index     = drain_if.data[BYTE_W];
	assign wr_data      = drain_if.data[BYTE_W-1:0];

endmodule

// ---- sim/bus_master_model.sv ----
// Bus master model for the two-wire link
`timescale 1ns/10ps
module bus_master_model (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_lo
);
	// ==============================
	// Link idles high, clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	task automatic q;
		repeat (2) @(negedge mclk);
	endtask
	// Clock parked low with data released, as in a stuck ack slot
	task automatic clk_low;
		scl = 1'b0;
		q();
		sda_lo = 1'b0;
		q();
	endtask
	task automatic bit_io(input logic b, output logic r);
		scl = 1'b0;
		q();
		sda_lo = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
	endtask
	task automatic start;
		scl = 1'b0;
		q();
		sda_lo = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_lo = 1'b1;
		q();
	endtask
	task automatic stop;
		scl = 1'b0;
		q();
		sda_lo = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_lo = 1'b0;
		q();
	endtask
	// Ninth bit: release to read an ack, pull low to give one
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
		output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ai, ao);
	endtask
endmodule

// ---- sim/pmbus_port_assertions.sv ----
// Pin-level checks of the command port
`timescale 1ns/10ps
module pmbus_port_assertions
	import pmbus_port_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic              mclk,
	input wire logic              reset,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              sda_oe,
	input wire logic              timeout_en,
	input wire logic [BYTE_W-1:0] cmd_ptr,
	input wire logic              cmd_strobe,
	input wire logic              rd_strobe,
	input wire logic              clear_faults,
	input wire logic              wr_valid,
	input wire logic              wr_ready,
	input wire logic [BYTE_W-1:0] wr_ptr,
	input wire logic              wr_index,
	input wire logic [BYTE_W-1:0] wr_data
);
	int   oe_quiet_r;
	logic scl_last_r;

	// ==============================
	// Cycles of pulling low with a still clock
	always_ff @(posedge mclk) begin
		scl_last_r <= scl_in;
		if (reset || !sda_oe || scl_last_r != scl_in) begin
			oe_quiet_r <= 0;
		end else begin
			oe_quiet_r <= oe_quiet_r + 1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_drive;
		sda_oe [*6];
	endsequence
	property p_chg_low;
		$changed(sda_oe) |-> !scl_in && !$past(scl_in);
	endproperty
	a_chg_low: assert property (p_chg_low) else $error("drive moved, clock high");
	property p_bit_len;
		$rose(sda_oe) |-> s_drive;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("drive too short");
	property p_ptr;
		$changed(cmd_ptr) |-> ##[0:1] cmd_strobe;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer moved alone");
	property p_cmd;
		cmd_strobe |-> !scl_in ##1 !cmd_strobe;
	endproperty
	a_cmd: assert property (p_cmd) else $error("bad command strobe");
	property p_clear;
		clear_faults |-> scl_in && sda_in ##1 !clear_faults;
	endproperty
	a_clear: assert property (p_clear) else $error("bad clear pulse");
	property p_rd;
		rd_strobe |=> !rd_strobe;
	endproperty
	a_rd: assert property (p_rd) else $error("read strobe too long");
	property p_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable({wr_ptr, wr_index, wr_data});
	endproperty
	a_hold: assert property (p_hold) else $error("stalled entry moved");
	property p_fell;
		$fell(wr_valid) |-> $past(wr_ready);
	endproperty
	a_fell: assert property (p_fell) else $error("entry lost");
	property p_timeout;
		timeout_en && oe_quiet_r > TIMEOUT_CYCLES + 10 |-> !sda_oe;
	endproperty
	a_timeout: assert property (p_timeout) else $error("bus not released");
endmodule

// ---- sim/test_pmbus_slave_command_port.sv ----
// Self-checking bench of the command port
`timescale 1ns/10ps
module test_pmbus_slave_command_port
	import pmbus_port_pkg::*;
();
	localparam int         TO  = 200;
	localparam logic [6:0] DEV = 7'h2c;
	logic              mclk = 1'b0;
	logic              reset = 1'b1;
	logic              timeout_en = 1'b0;
	logic              word_cmd = 1'b0;
	logic [WORD_W-1:0] rd_data = 16'h0000;
	logic              wr_ready = 1'b1;
	logic              scl, sda_lo, sda_oe, sda_out, ak, wr_index, wr_valid;
	logic              cmd_strobe, rd_strobe, clear_faults;
	logic [BYTE_W-1:0] cmd_ptr, wr_ptr, wr_data, rx;
	wire               sda;
	logic [23:0]       pops[$];
	int                failures = 0, checked = 0, cyc = 0, cf_n = 0, rd_n = 0, cs_n = 0;

	always #25 mclk = ~mclk;
	// Pull-up wins unless someone pulls low
	assign sda = (sda_oe ? sda_out : 1'b1) & !sda_lo;

	pmbus_slave_command_port #(.TIMEOUT_CYCLES(TO)) u_dut (
		.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .dev_addr(DEV), .timeout_en(timeout_en), .word_cmd(word_cmd),
		.rd_data(rd_data), .cmd_ptr(cmd_ptr), .cmd_strobe(cmd_strobe),
		.rd_strobe(rd_strobe), .clear_faults(clear_faults), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_ptr(wr_ptr), .wr_index(wr_index), .wr_data(wr_data));
	bus_master_model u_m (.mclk(mclk), .sda(sda), .scl(scl), .sda_lo(sda_lo));

	// ==============================
	// Monitor and hang guard
	always @(posedge mclk) begin
		cyc++;
		if (clear_faults === 1'b1) cf_n++;
		if (rd_strobe === 1'b1) rd_n++;
		if (cmd_strobe === 1'b1) cs_n++;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) pops.push_back({wr_ptr, wr_index, wr_data});
		if (cyc == 30000) begin
			failures++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic b(input logic [7:0] tx, input logic ai);
		u_m.xfer(tx, ai, rx, ak);
	endtask
	task automatic head(input logic [7:0] c);
		u_m.start();
		b({DEV, 1'b0}, 1'b1);
		chk("addr_ack", 0, ak);
		b(c, 1'b1);
		chk("cmd_ack", 0, ak);
	endtask

	// ==============================
	// Scenarios
	task automatic t_send;
		int n;
		int c;
		n = cf_n;
		c = cs_n;
		head(8'h03);
		u_m.stop();
		repeat (8) @(negedge mclk);
		chk("cmd_ptr", 8'h03, cmd_ptr);
		chk("cmd_strobe", c + 1, cs_n);
		chk("clear", n + 1, cf_n);
		$display("send end");
	endtask
	task automatic t_wword;
		pops.delete();
		head(8'h21);
		b(8'h34, 1'b1);
		chk("d0_ack", 0, ak);
		b(8'h12, 1'b1);
		chk("d1_ack", 0, ak);
		b(8'h56, 1'b1);
		chk("d2_nack", 1, ak);
		u_m.stop();
		repeat (8) @(negedge mclk);
		chk("pops", 2, pops.size());
		chk("lo", {8'h21, 1'b0, 8'h34}, pops[0]);
		chk("hi", {8'h21, 1'b1, 8'h12}, pops[1]);
		$display("word write end");
	endtask
	task automatic t_read(input logic w);
		int n;
		n = rd_n;
		word_cmd = w;
		rd_data = 16'hbeef;
		head(8'h40);
		u_m.start();
		b({DEV, 1'b1}, 1'b1);
		chk("rd_ack", 0, ak);
		chk("rd_strobe", n + 1, rd_n);
		b(8'hff, !w);
		chk("rd_lo", 8'hef, rx);
		if (w) begin
			b(8'hff, 1'b1);
			chk("rd_hi", 8'hbe, rx);
		end
		u_m.stop();
		$display("read end");
	endtask
	task automatic t_refuse;
		u_m.start();
		b({DEV ^ 7'h01, 1'b0}, 1'b1);
		chk("other_addr", 1, ak);
		u_m.stop();
		u_m.start();
		b({DEV, 1'b1}, 1'b1);
		chk("no_cmd_rd", 1, ak);
		u_m.stop();
		$display("refuse end");
	endtask
	task automatic t_stall;
		int n;
		n = cf_n;
		wr_ready = 1'b0;
		pops.delete();
		head(8'h22);
		b(8'h11, 1'b1);
		b(8'h22, 1'b1);
		chk("fill_ack", 0, ak);
		u_m.stop();
		head(8'h23);
		b(8'h33, 1'b1);
		chk("full_nack", 1, ak);
		u_m.stop();
		chk("held", 1, wr_valid);
		wr_ready = 1'b1;
		repeat (4) @(negedge mclk);
		chk("no_clear", n, cf_n);
		chk("drained", 2, pops.size());
		chk("kept_lo", {8'h22, 1'b0, 8'h11}, pops[0]);
		chk("kept_hi", {8'h22, 1'b1, 8'h22}, pops[1]);
		chk("empty", 0, wr_valid);
		$display("stall end");
	endtask
	task automatic t_timeout;
		logic r;
		timeout_en = 1'b1;
		u_m.start();
		for (int i = 6; i >= 0; i--) u_m.bit_io(DEV[i], r);
		u_m.bit_io(1'b0, r);
		// Stall in the ack slot so the port keeps pulling low
		u_m.clk_low();
		repeat (8) @(negedge mclk);
		chk("ack_held", 1, sda_oe);
		repeat (TO + 20) @(negedge mclk);
		chk("released", 0, sda_oe);
		u_m.stop();
		timeout_en = 1'b0;
		$display("timeout end");
	endtask

	task automatic summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		t_send();
		t_wword();
		t_read(1'b0);
		t_read(1'b1);
		t_refuse();
		t_stall();
		t_timeout();
		summarize();
	end
endmodule

bind pmbus_slave_command_port pmbus_port_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
	.timeout_en(timeout_en), .cmd_ptr(cmd_ptr), .cmd_strobe(cmd_strobe),
	.rd_strobe(rd_strobe), .clear_faults(clear_faults), .wr_valid(wr_valid),
	.wr_ready(wr_ready), .wr_ptr(wr_ptr), .wr_index(wr_index), .wr_data(wr_data));
